// file: sim/acmr_core_model.sv
// Converter core model: elementary conversions, done pulse, data ready
`timescale 1ns/1ps
`default_nettype none
module acmr_core_model #(
  parameter int NEL = 4
) (
  input  wire logic i_clk,
  input  wire logic i_nrst,
  input  wire logic i_start,
  input  wire logic i_stray,
  output logic      o_elconv_done,
  output logic      o_conv_done,
  output logic      o_data_ready
);
  logic [3:0] cnt_reg;
  logic [1:0] tick_reg;
  logic       run_reg;
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      {run_reg, cnt_reg, tick_reg, o_data_ready} <= '0;
    end else if (i_start) begin
      {run_reg, cnt_reg, tick_reg, o_data_ready} <= {1'b1, 7'h00};
    end else if (run_reg) begin
      tick_reg <= tick_reg + 2'h1;
      if (o_elconv_done) cnt_reg <= cnt_reg + 4'h1;
      if (o_conv_done) {run_reg, o_data_ready} <= 2'h1;
    end
  end
  // Stray pulse lets the bench probe idle refusal
  assign o_elconv_done = (run_reg && tick_reg == 2'h3 && cnt_reg < 4'(NEL)) || i_stray;
  assign o_conv_done = run_reg && tick_reg == 2'h3 && cnt_reg == 4'(NEL);
endmodule // acmr_core_model
`default_nettype wire

// file: sim/acmr_regs_chk.sv
// Checker for the converter config register bank ports
`timescale 1ns/1ps
`default_nettype none
module acmr_regs_chk
  import acmr_pkg::*;
(
  input wire logic       i_clk,
  input wire logic       i_nrst,
  input wire acmr_req_t  i_req,
  input wire logic [7:0] o_rdata,
  input wire logic       i_elconv_done, i_conv_done, i_data_ready,
  input wire logic       o_conv_start, o_load_defaults, o_conv_active, o_chop_state, o_pump_on,
  input wire acmr_cfg_t  o_cfg,
  input wire logic       o_ref_out_on_pad0, o_ext_ref_on_pad1, o_ready_on_serial_out, o_serial_out_ready
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  logic wm;
  logic launch;
  assign wm = i_req.wr && i_req.addr == ACMR_OFS_MODE;
  sequence start_s; i_req.wr && i_req.addr == ACMR_OFS_CONV_CTRL && i_req.wdata[7]; endsequence
  sequence def_s; i_req.wr && i_req.addr == ACMR_OFS_INPUT_ACT && i_req.wdata[6]; endsequence
  sequence run_s; o_conv_start && o_conv_active; endsequence
  assign launch = i_req.wr && ((i_req.addr == ACMR_OFS_CONV_CTRL && i_req.wdata[7]) ||
                               (i_req.addr == ACMR_OFS_INPUT_ACT && i_req.wdata[6]));
  start_go_a:
    assert property (start_s |=> run_s) else $error("start write did not launch");
  def_load_a:
    assert property (def_s |=> run_s ##0 o_load_defaults && o_cfg.stage3_gain == 7'h0C && o_cfg.input_select == 5'h00)
    else $error("default write did not load defaults");
  done_idle_a:
    assert property (i_conv_done && !launch |=> !o_conv_active) else $error("activity stayed after done");
  busy_read_a:
    assert property (i_req.rd && i_req.addr == ACMR_OFS_INPUT_ACT |=> o_rdata[7] == $past(o_conv_active))
    else $error("activity flag readback wrong");
  chop_idle_a:
    assert property (i_elconv_done && !o_conv_active && !wm |=> $stable(o_chop_state)) else $error("chop moved idle");
  chop_hold_a:
    assert property (wm && !i_req.wdata[5] |-> ##2 o_chop_state == $past(i_req.wdata[4], 2)) else $error("chop hold wrong");
  pump_ctl_a:
    assert property (wm |=> o_pump_on == ($past(i_req.wdata[3]) || !$past(i_req.wdata[2])))
    else $error("pump control wrong");
  pad_route_a:
    assert property (wm |=> o_ref_out_on_pad0 == $past(i_req.wdata[1]) && o_ext_ref_on_pad1 == $past(i_req.wdata[0]))
    else $error("pad routing wrong");
  ready_comb_a:
    assert property (o_serial_out_ready == (o_ready_on_serial_out && i_data_ready)) else $error("ready combine wrong");
endmodule // acmr_regs_chk
bind acmr_regs acmr_regs_chk acmr_regs_chk_inst (.i_clk(i_clk), .i_nrst(i_nrst), .i_req(i_req), .o_rdata(o_rdata),
  .i_elconv_done(i_elconv_done), .i_conv_done(i_conv_done), .i_data_ready(i_data_ready), .o_conv_start(o_conv_start),
  .o_load_defaults(o_load_defaults), .o_conv_active(o_conv_active), .o_chop_state(o_chop_state), .o_pump_on(o_pump_on),
  .o_cfg(o_cfg), .o_ref_out_on_pad0(o_ref_out_on_pad0), .o_ext_ref_on_pad1(o_ext_ref_on_pad1),
  .o_ready_on_serial_out(o_ready_on_serial_out), .o_serial_out_ready(o_serial_out_ready));
`default_nettype wire

// file: sim/tb_top.sv
// Self-checking bench for the converter config register bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import acmr_pkg::*;
  logic       i_clk = 1'b0, i_nrst = 1'b0, stray = 1'b0;
  acmr_req_t  i_req = '0;
  logic [7:0] o_rdata, rv;
  logic       elc, cdone, drdy, cstart, ldef, act, chop, pump, pad0, pad1, rdyo, sready;
  acmr_cfg_t  cfg;
  int         num_errors = 0, checks = 0, togs = 0, cyc = 0;
  always #4 i_clk = ~i_clk;
  always @(chop) togs++;
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      results();
    end
  end
  acmr_regs acmr_regs_inst (.i_clk(i_clk), .i_nrst(i_nrst), .i_req(i_req), .o_rdata(o_rdata), .i_elconv_done(elc),
    .i_conv_done(cdone), .i_data_ready(drdy), .o_conv_start(cstart), .o_load_defaults(ldef), .o_cfg(cfg),
    .o_conv_active(act), .o_chop_state(chop), .o_pump_on(pump), .o_ref_out_on_pad0(pad0), .o_ext_ref_on_pad1(pad1),
    .o_ready_on_serial_out(rdyo), .o_serial_out_ready(sready));
  acmr_core_model acmr_core_model_inst (.i_clk(i_clk), .i_nrst(i_nrst), .i_start(cstart), .i_stray(stray),
    .o_elconv_done(elc), .o_conv_done(cdone), .o_data_ready(drdy));
  task automatic results();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic cmp(input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("Error at %0t: expected %h got %h", $time, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk) i_req <= '{1'b1, 1'b0, a, d};
    @(posedge i_clk) i_req <= '0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge i_clk) i_req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge i_clk) i_req <= '0;
    #1 rv = o_rdata;
  endtask
  task automatic wait_idle();
    for (int k = 0; k < 100 && act === 1'b1; k++) @(posedge i_clk);
    #1 cmp(8'h00, {7'h00, act});
  endtask
  task automatic t_reset();
    logic [7:0] a [7] = '{8'h54, 8'h55, 8'h56, 8'h57, 8'h70, 8'h52, 8'h60};
    logic [7:0] e [7] = '{8'h00, 8'h0C, 8'h00, 8'h00, 8'h84, 8'h00, 8'h00};
    cmp(8'h00, {7'h00, pump});
    foreach (a[i]) begin
      rd(a[i]);
      cmp(e[i], rv);
    end
  endtask
  task automatic t_rw();
    logic [7:0] a [5] = '{8'h54, 8'h55, 8'h56, 8'h57, 8'h70};
    logic [7:0] w [5] = '{8'hC5, 8'h85, 8'h7A, 8'hBE, 8'h4B};
    logic [7:0] e [5] = '{8'hC5, 8'h85, 8'h7A, 8'h3E, 8'h8B};
    foreach (a[i]) begin
      wr(a[i], w[i]);
      rd(a[i]);
      cmp(e[i], rv);
    end
  endtask
  task automatic t_mode();
    for (int i = 0; i < 4; i++) begin
      wr(8'h70, {4'h0, i[1:0], ~i[1:0]});
      cmp({7'h00, i[1] | ~i[0]}, {7'h00, pump});
      cmp({6'h00, ~i[1:0]}, {6'h00, pad0, pad1});
    end
  endtask
  task automatic t_conv(input logic [1:0] m, input int n);
    int t;
    wr(8'h70, {2'h0, m, 4'h4});
    // Hold modes move the chop one edge after the write lands
    @(posedge i_clk);
    #1 t = togs;
    wr(8'h52, 8'h80);
    cmp(8'h03, {6'h00, cstart, act});
    cmp(8'h05, {1'b0, cfg.stage3_gain});
    rd(8'h57);
    cmp(8'h80, rv & 8'h80);
    wait_idle();
    cmp(n[7:0], 8'(togs - t));
    cmp({7'h00, m[1] ? n[0] : m[0]}, {7'h00, chop});
  endtask
  task automatic t_ready();
    wr(8'h56, 8'h80);
    cmp(8'h03, {6'h00, rdyo, sready});
    wr(8'h56, 8'h00);
    cmp(8'h00, {6'h00, rdyo, sready});
  endtask
  task automatic t_def();
    wr(8'h57, 8'h40);
    cmp(8'h03, {6'h00, ldef, act});
    cmp(8'h0C, {1'b0, cfg.stage3_gain});
    wait_idle();
  endtask
  task automatic t_stray();
    int t;
    wr(8'h70, 8'h24);
    t = togs;
    @(posedge i_clk) stray <= 1'b1;
    @(posedge i_clk) stray <= 1'b0;
    repeat (2) @(posedge i_clk);
    #1 cmp(8'h00, 8'(togs - t));
  endtask
  initial begin
    repeat (6) @(posedge i_clk);
    i_nrst <= 1'b1;
    t_reset();
    t_rw();
    t_mode();
    t_conv(2'h2, 4);
    t_conv(2'h3, 2);
    t_conv(2'h1, 0);
    t_conv(2'h0, 0);
    t_ready();
    t_def();
    t_stray();
    results();
  end
endmodule // tb_top
`default_nettype wire

// file: verilog/acmr_pkg.sv
// Package: offsets, field positions, reset values and types of the converter config registers
package acmr_pkg;

  // Register offsets
  localparam logic [7:0] ACMR_OFS_CONV_CTRL    = 8'h52;
  localparam logic [7:0] ACMR_OFS_RATE_STAGE2  = 8'h54;
  localparam logic [7:0] ACMR_OFS_STAGE13_GAIN = 8'h55;
  localparam logic [7:0] ACMR_OFS_READY_STAGE3 = 8'h56;
  localparam logic [7:0] ACMR_OFS_INPUT_ACT    = 8'h57;
  localparam logic [7:0] ACMR_OFS_MODE         = 8'h70;

  // Field positions
  localparam int ACMR_START_BIT       = 7;
  localparam int ACMR_RATE_HI         = 7;
  localparam int ACMR_RATE_LO         = 6;
  localparam int ACMR_S2GAIN_HI       = 5;
  localparam int ACMR_S2GAIN_LO       = 4;
  localparam int ACMR_S2OFS_HI        = 3;
  localparam int ACMR_S1GAIN_BIT      = 7;
  localparam int ACMR_S3GAIN_HI       = 6;
  localparam int ACMR_READY_BIT       = 7;
  localparam int ACMR_S3OFS_HI        = 6;
  localparam int ACMR_ACTIVE_BIT      = 7;
  localparam int ACMR_DEFAULT_BIT     = 6;
  localparam int ACMR_INSEL_HI        = 5;
  localparam int ACMR_INSEL_LO        = 1;
  localparam int ACMR_REFSEL_BIT      = 0;
  localparam int ACMR_CHOP_HI         = 5;
  localparam int ACMR_CHOP_LO         = 4;
  localparam int ACMR_PUMP_ON_BIT     = 3;
  localparam int ACMR_PUMP_OFF_BIT    = 2;
  localparam int ACMR_REF_OUT_BIT     = 1;
  localparam int ACMR_EXT_REF_BIT     = 0;

  // Reset values
  localparam logic [7:0] ACMR_RST_RATE_STAGE2  = 8'h00;
  localparam logic [7:0] ACMR_RST_STAGE13_GAIN = 8'h0C;
  localparam logic [7:0] ACMR_RST_READY_STAGE3 = 8'h00;
  localparam logic [6:0] ACMR_RST_INPUT_ACT    = 7'h00;
  localparam logic [1:0] ACMR_RST_MODE_RSVD    = 2'h2;
  localparam logic [1:0] ACMR_RST_CHOP         = 2'h0;
  localparam logic       ACMR_RST_PUMP_ON      = 1'b0;
  localparam logic       ACMR_RST_PUMP_OFF     = 1'b1;
  localparam logic [7:0] ACMR_RDATA_UNMAPPED   = 8'h00;

  // Chop modes
  typedef enum logic [1:0] {
    ACMR_CHOP_HOLD0 = 2'h0,
    ACMR_CHOP_HOLD1 = 2'h1,
    ACMR_CHOP_EVERY = 2'h2,
    ACMR_CHOP_HALF  = 2'h3
  } acmr_chop_t;

  // Register write/read request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } acmr_req_t;

  // Conversion settings handed to the converter core
  typedef struct packed {
    logic [1:0] sample_rate_select;
    logic [1:0] stage2_gain;
    logic [3:0] stage2_offset;
    logic       stage1_gain;
    logic [6:0] stage3_gain;
    logic [6:0] stage3_offset;
    logic [4:0] input_select;
    logic       ref_select;
  } acmr_cfg_t;

endpackage : acmr_pkg

// file: verilog/acmr_regs.sv
// Converter configuration and mode register bank with chop and pump control
`timescale 1ns/1ps
`default_nettype none

// Operation
// - A two-bit sample rate field sits in bits 7:6 of the rate/stage2 register and resets to zero.
// - With the ready-combine bit set, conversion-data-ready is signalled on the serial output line.
// - A five-bit input selector sits in bits 5:1 of the input/activity register and resets to zero.
// - Bit 0 of the input/activity register picks the reference: 0 battery supply, 1 reference voltage.
// - Writing 1 to the default bit loads the default configuration and launches a conversion.
// - Chop field 11 toggles every two elementary conversions, 10 every one, 01 holds 1, 00 holds 0.
// - In the toggling chop settings the chop state changes only while a conversion runs.
// - Pump force-on turns the charge pump on and beats force-off.
// - Pump force-off turns the pump off unless force-on is set, and resets to 1.
// - Mode bit 1 routes the internal reference out on general pad 0.
// - Mode bit 0 takes an external reference on general pad 1 instead of driving it.
// - Writing 1 to the start bit of the first config register begins a conversion.
module acmr_regs (
  // Clock and reset
  input  wire logic                 i_clk,
  input  wire logic                 i_nrst,
  // Register access
  input  wire acmr_pkg::acmr_req_t  i_req,
  output logic [7:0]                o_rdata,
  // Converter core
  input  wire logic                 i_elconv_done,
  input  wire logic                 i_conv_done,
  input  wire logic                 i_data_ready,
  output logic                      o_conv_start,
  output logic                      o_load_defaults,
  output acmr_pkg::acmr_cfg_t       o_cfg,
  output logic                      o_conv_active,
  // Analog and pad control
  output logic                      o_chop_state,
  output logic                      o_pump_on,
  output logic                      o_ref_out_on_pad0,
  output logic                      o_ext_ref_on_pad1,
  output logic                      o_ready_on_serial_out,
  output logic                      o_serial_out_ready
);
  import acmr_pkg::*;

  logic [7:0] rate_and_stage2_setup_reg;
  logic [7:0] stage1_stage3_gain_reg;
  logic [7:0] ready_combine_stage3_offset_reg;
  logic [6:0] input_select_reg;
  logic [1:0] chop_reg;
  logic       pump_force_on_reg;
  logic       pump_force_off_reg;
  logic       ref_out_on_pad0_reg;
  logic       ext_ref_on_pad1_reg;
  logic       active_reg;
  logic       half_phase_reg;
  logic       chop_state_reg;
  logic       chop_state_next;
  logic       start_pulse_reg;
  logic       defaults_pulse_reg;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  acmr_cfg_t  cfg_reg;
  acmr_cfg_t  cfg_default;
  logic       wr_start;
  logic       wr_default;
  logic       launch;

  assign wr_start   = i_req.wr && (i_req.addr == ACMR_OFS_CONV_CTRL) && i_req.wdata[ACMR_START_BIT];
  assign wr_default = i_req.wr && (i_req.addr == ACMR_OFS_INPUT_ACT) && i_req.wdata[ACMR_DEFAULT_BIT];
  assign launch     = wr_start || wr_default;

  // Stored configuration fields
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rate_and_stage2_setup_reg       <= ACMR_RST_RATE_STAGE2;
      stage1_stage3_gain_reg          <= ACMR_RST_STAGE13_GAIN;
      ready_combine_stage3_offset_reg <= ACMR_RST_READY_STAGE3;
      input_select_reg                <= ACMR_RST_INPUT_ACT;
    end else if (i_req.wr) begin
      case (i_req.addr)
        ACMR_OFS_RATE_STAGE2:  rate_and_stage2_setup_reg       <= i_req.wdata;
        ACMR_OFS_STAGE13_GAIN: stage1_stage3_gain_reg          <= i_req.wdata;
        ACMR_OFS_READY_STAGE3: ready_combine_stage3_offset_reg <= i_req.wdata;
        ACMR_OFS_INPUT_ACT:    input_select_reg                <= i_req.wdata[6:0];
        default: ;
      endcase
    end
  end

  // Mode register; bits 7:6 are fixed reserved values
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      chop_reg            <= ACMR_RST_CHOP;
      pump_force_on_reg   <= ACMR_RST_PUMP_ON;
      pump_force_off_reg  <= ACMR_RST_PUMP_OFF;
      ref_out_on_pad0_reg <= 1'b0;
      ext_ref_on_pad1_reg <= 1'b0;
    end else if (i_req.wr && (i_req.addr == ACMR_OFS_MODE)) begin
      chop_reg            <= i_req.wdata[ACMR_CHOP_HI:ACMR_CHOP_LO];
      pump_force_on_reg   <= i_req.wdata[ACMR_PUMP_ON_BIT];
      pump_force_off_reg  <= i_req.wdata[ACMR_PUMP_OFF_BIT];
      ref_out_on_pad0_reg <= i_req.wdata[ACMR_REF_OUT_BIT];
      ext_ref_on_pad1_reg <= i_req.wdata[ACMR_EXT_REF_BIT];
    end
  end

  // Default conversion setup: the reset image of the fields
  always_comb begin
    cfg_default                    = '0;
    cfg_default.sample_rate_select = ACMR_RST_RATE_STAGE2[ACMR_RATE_HI:ACMR_RATE_LO];
    cfg_default.stage2_gain        = ACMR_RST_RATE_STAGE2[ACMR_S2GAIN_HI:ACMR_S2GAIN_LO];
    cfg_default.stage2_offset      = ACMR_RST_RATE_STAGE2[ACMR_S2OFS_HI:0];
    cfg_default.stage1_gain        = ACMR_RST_STAGE13_GAIN[ACMR_S1GAIN_BIT];
    cfg_default.stage3_gain        = ACMR_RST_STAGE13_GAIN[ACMR_S3GAIN_HI:0];
    cfg_default.stage3_offset      = ACMR_RST_READY_STAGE3[ACMR_S3OFS_HI:0];
    cfg_default.input_select       = ACMR_RST_INPUT_ACT[ACMR_INSEL_HI:ACMR_INSEL_LO];
    cfg_default.ref_select         = ACMR_RST_INPUT_ACT[ACMR_REFSEL_BIT];
  end

  // Settings sampled at launch so a mid-conversion write waits for the next one
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cfg_reg <= '0;
    end else if (wr_default) begin
      cfg_reg <= cfg_default;
    end else if (wr_start) begin
      cfg_reg.sample_rate_select <= rate_and_stage2_setup_reg[ACMR_RATE_HI:ACMR_RATE_LO];
      cfg_reg.stage2_gain        <= rate_and_stage2_setup_reg[ACMR_S2GAIN_HI:ACMR_S2GAIN_LO];
      cfg_reg.stage2_offset      <= rate_and_stage2_setup_reg[ACMR_S2OFS_HI:0];
      cfg_reg.stage1_gain        <= stage1_stage3_gain_reg[ACMR_S1GAIN_BIT];
      cfg_reg.stage3_gain        <= stage1_stage3_gain_reg[ACMR_S3GAIN_HI:0];
      cfg_reg.stage3_offset      <= ready_combine_stage3_offset_reg[ACMR_S3OFS_HI:0];
      cfg_reg.input_select       <= input_select_reg[ACMR_INSEL_HI:ACMR_INSEL_LO];
      cfg_reg.ref_select         <= input_select_reg[ACMR_REFSEL_BIT];
    end
  end

  // Launch pulses toward the converter core
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      start_pulse_reg    <= 1'b0;
      defaults_pulse_reg <= 1'b0;
    end else begin
      start_pulse_reg    <= launch;
      defaults_pulse_reg <= wr_default;
    end
  end

  // Activity flag; a launch in the done cycle keeps it set
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      active_reg <= 1'b0;
    end else if (launch) begin
      active_reg <= 1'b1;
    end else if (i_conv_done) begin
      active_reg <= 1'b0;
    end
  end

  // Chop state; toggles only while active
  always_comb begin
    chop_state_next = chop_state_reg;
    case (acmr_chop_t'(chop_reg))
      ACMR_CHOP_HOLD0: chop_state_next = 1'b0;
      ACMR_CHOP_HOLD1: chop_state_next = 1'b1;
      ACMR_CHOP_EVERY: if (active_reg && i_elconv_done) begin
        chop_state_next = ~chop_state_reg;
      end
      ACMR_CHOP_HALF: if (active_reg && i_elconv_done && half_phase_reg) begin
        chop_state_next = ~chop_state_reg;
      end
      default: chop_state_next = chop_state_reg;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      chop_state_reg <= 1'b0;
      half_phase_reg <= 1'b0;
    end else begin
      chop_state_reg <= chop_state_next;
      if (launch) begin
        half_phase_reg <= 1'b0;
      end else if (active_reg && i_elconv_done) begin
        half_phase_reg <= ~half_phase_reg;
      end
    end
  end

  // Read mux; unmapped offsets read zero
  always_comb begin
    case (i_req.addr)
      ACMR_OFS_RATE_STAGE2:  rdata_next = rate_and_stage2_setup_reg;
      ACMR_OFS_STAGE13_GAIN: rdata_next = stage1_stage3_gain_reg;
      ACMR_OFS_READY_STAGE3: rdata_next = ready_combine_stage3_offset_reg;
      ACMR_OFS_INPUT_ACT:    rdata_next = {active_reg, input_select_reg};
      ACMR_OFS_MODE:         rdata_next = {ACMR_RST_MODE_RSVD, chop_reg, pump_force_on_reg,
                                           pump_force_off_reg, ref_out_on_pad0_reg, ext_ref_on_pad1_reg};
      default:               rdata_next = ACMR_RDATA_UNMAPPED;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rdata_reg <= ACMR_RDATA_UNMAPPED;
    end else if (i_req.rd) begin
      rdata_reg <= rdata_next;
    end
  end

  assign o_rdata               = rdata_reg;
  assign o_conv_start          = start_pulse_reg;
  assign o_load_defaults       = defaults_pulse_reg;
  assign o_cfg                 = cfg_reg;
  assign o_conv_active         = active_reg;
  assign o_chop_state          = chop_state_reg;
  assign o_pump_on             = pump_force_on_reg || !pump_force_off_reg;
  assign o_ref_out_on_pad0     = ref_out_on_pad0_reg;
  assign o_ext_ref_on_pad1     = ext_ref_on_pad1_reg;
  assign o_ready_on_serial_out = ready_combine_stage3_offset_reg[ACMR_READY_BIT];
  // Combinational so the ready edge reaches the line without a cycle of lag
  assign o_serial_out_ready    = ready_combine_stage3_offset_reg[ACMR_READY_BIT] && i_data_ready;

endmodule : acmr_regs

`default_nettype wire
